// ===== rtl/tag_pkg.sv
// Notes on behaviour
// - Critical control bits, the watchdog control bits among them, change only while the timed window is open.
// - The key register sits at special function register address C7h.
// - A write of AAh to the key register starts a counter that waits for a 55h write.
// - The window opens only if the 55h write comes within 3 machine cycles of the AAh write.
// - A 55h write 4 machine cycles after the AAh write opens nothing, and a later protected write fails.
// - An open window stays open for 3 machine cycles and then closes by itself.
// - A protected write is applied only while the window is open; outside it the write is dropped.
package tag_pkg;
   localparam logic [7:0] TAG_KEY_ADDR = 8'hC7;
   localparam logic [7:0] TAG_KEY_FIRST = 8'hAA;
   localparam logic [7:0] TAG_KEY_SECOND = 8'h55;
   localparam logic [7:0] TAG_WDOG_ADDR_DEF = 8'hD8;
   localparam logic [7:0] TAG_WDOG_RESET = 8'h00;
   localparam int TAG_ARM_MC = 3;
   localparam int TAG_OPEN_MC = 3;
   localparam int TAG_MC_CLKS = 4;
   localparam logic [1:0] TAG_CNT_ZERO = 2'h0;
   localparam logic [1:0] TAG_CNT_ONE = 2'h1;
   typedef enum logic [2:0]
   {
      TAG_IDLE = 3'h1,
      TAG_ARMED = 3'h2,
      TAG_OPEN = 3'h4
   } tag_state_t;
endpackage : tag_pkg

// ===== rtl/tag_mc_tick.sv
// machine cycle strobe: one pulse every mc_clks clocks
module tag_mc_tick
   import tag_pkg::*;
#(
   parameter int MC_CLKS = TAG_MC_CLKS
)
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   output logic tick_out
);
   typedef struct packed
   {
      logic [7:0] cnt;
      logic tick;
   } tag_tick_st_t;
   tag_tick_st_t cur_ff;
   tag_tick_st_t nxt_cur;
   localparam logic [7:0] LAST = 8'(MC_CLKS - 1);

   // free running divider
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.tick = (cur_ff.cnt == LAST);
      nxt_cur.cnt = nxt_cur.tick ? 8'h00 : 8'(cur_ff.cnt + 8'h01);
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         cur_ff <= '0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   assign tick_out = cur_ff.tick;
endmodule : tag_mc_tick

// ===== rtl/tag_guard.sv
// timed write guard for protected special function register bits
module tag_guard
   import tag_pkg::*;
#(
   parameter int MC_CLKS = TAG_MC_CLKS,
   parameter logic [7:0] WDOG_ADDR = TAG_WDOG_ADDR_DEF,
   parameter logic [7:0] PROT_MASK = 8'hFF
)
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   output logic [7:0] watchdog_control_out,
   output logic window_open_out,
   output logic wr_dropped_out
);
   typedef struct packed
   {
      tag_state_t st;
      logic [1:0] mc;
      logic [7:0] wdog;
      logic drop;
   } tag_guard_st_t;
   tag_guard_st_t cur_ff;
   tag_guard_st_t nxt_cur;
   logic mc_tick;
   logic key_wr;
   logic wdog_wr;
   logic key_first; // first key value seen on the key register
   logic key_second; // second key value seen on the key register
   logic key_other; // any other value written to the key register
   localparam logic [1:0] ARM_LAST = 2'(TAG_ARM_MC);
   localparam logic [1:0] OPEN_LAST = 2'(TAG_OPEN_MC);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // a key register write that carries the given key value
   function automatic logic key_is(input logic wr, input logic [7:0] data, input logic [7:0] key);
      return wr && (data == key);
   endfunction : key_is

   // true on the machine cycle strobe that ends a span of last counted cycles
   function automatic logic span_done(input logic tick, input logic [1:0] mc, input logic [1:0] last);
      return tick && (mc == 2'(last - TAG_CNT_ONE));
   endfunction : span_done

   // bits under mask come from the write data, the others keep their old value
   function automatic logic [7:0] merge_bits(input logic [7:0] old, input logic [7:0] data,
      input logic [7:0] mask);
      return (old & ~mask) | (data & mask);
   endfunction : merge_bits

   ////////////////////////////////////////////////////////////////////////////
   // machine cycle timebase
   tag_mc_tick #(
      .MC_CLKS(MC_CLKS)
   ) u_tick (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .tick_out(mc_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // address decode
   always_comb
   begin
      key_wr = 1'b0;
      wdog_wr = 1'b0;
      if (sfr_wr_in && sfr_addr_in == TAG_KEY_ADDR)
      begin
         key_wr = 1'b1;
      end
      else if (sfr_wr_in && sfr_addr_in == WDOG_ADDR)
      begin
         wdog_wr = 1'b1;
      end
      // split key writes by value so the states test flags instead of the write data
      key_first = key_is(key_wr, sfr_wdata_in, TAG_KEY_FIRST);
      key_second = key_is(key_wr, sfr_wdata_in, TAG_KEY_SECOND);
      key_other = key_wr && !key_first && !key_second;
   end

   ////////////////////////////////////////////////////////////////////////////
   // key sequence and window
   // idle: waits for the first key; armed: waits for the second key while
   // counting machine cycles; open: protected writes land while counting.
   // the counter follows the free running strobe, so every span is
   // quantised to whole strobes and may be up to one machine cycle short.
   // a first key while armed or open starts the wait again, so software
   // that repeats the whole sequence is never locked out.
   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.drop = 1'b0;
      case (cur_ff.st)
         TAG_IDLE:
         begin
            nxt_cur.mc = TAG_CNT_ZERO;
            if (key_first)
            begin
               nxt_cur.st = TAG_ARMED;
            end
         end
         TAG_ARMED:
         begin
            if (key_second)
            begin
               nxt_cur.st = TAG_OPEN;
               nxt_cur.mc = TAG_CNT_ZERO;
            end
            else if (key_first)
            begin
               nxt_cur.mc = TAG_CNT_ZERO; // restart wait
            end
            else if (key_other)
            begin
               nxt_cur.st = TAG_IDLE;
            end
            else if (mc_tick)
            begin
               if (span_done(mc_tick, cur_ff.mc, ARM_LAST))
               begin
                  nxt_cur.st = TAG_IDLE;
               end
               else
               begin
                  nxt_cur.mc = 2'(cur_ff.mc + TAG_CNT_ONE);
               end
            end
         end
         TAG_OPEN:
         begin
            if (key_first)
            begin
               nxt_cur.st = TAG_ARMED;
               nxt_cur.mc = TAG_CNT_ZERO;
            end
            else if (mc_tick)
            begin
               if (span_done(mc_tick, cur_ff.mc, OPEN_LAST))
               begin
                  nxt_cur.st = TAG_IDLE;
               end
               else
               begin
                  nxt_cur.mc = 2'(cur_ff.mc + TAG_CNT_ONE);
               end
            end
         end
         default:
         begin
            nxt_cur.st = TAG_IDLE;
         end
      endcase
      // protected write: applied inside window only
      if (wdog_wr)
      begin
         if (cur_ff.st == TAG_OPEN)
         begin
            nxt_cur.wdog = merge_bits(cur_ff.wdog, sfr_wdata_in, PROT_MASK);
         end
         else
         begin
            nxt_cur.wdog = merge_bits(cur_ff.wdog, sfr_wdata_in, ~PROT_MASK);
            nxt_cur.drop = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   // reset leaves the window closed and the protected bits at their reset
   // value, so a reset in mid window cannot leave a write path open.
   // the drop flag is a one cycle pulse and needs no clear from software.
   // every field is reset on its own so the reset branch holds constants only.
   always_ff @(posedge mclk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         cur_ff.st <= TAG_IDLE;
         cur_ff.mc <= TAG_CNT_ZERO;
         cur_ff.wdog <= TAG_WDOG_RESET;
         cur_ff.drop <= 1'b0;
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // all outputs come straight from the state register
   assign watchdog_control_out = cur_ff.wdog;
   assign window_open_out = (cur_ff.st == TAG_OPEN);
   assign wr_dropped_out = cur_ff.drop;
endmodule : tag_guard

// ===== verification/tag_cpu_model.sv
// cpu side: one sfr write per call, never back to back
module tag_cpu_model
   import tag_pkg::*;
(
   input wire logic mclk_in,
   output logic sfr_wr_out = 1'h0,
   output logic [7:0] sfr_addr_out = 8'h00,
   output logic [7:0] sfr_wdata_out = 8'h00
);
   timeunit 1ns;
   timeprecision 100ps;
   // drive after an edge, hold one cycle, then show the inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      #1 sfr_wr_out = 1'h1;
      sfr_addr_out = a;
      sfr_wdata_out = d;
      @(posedge mclk_in);
      #1 sfr_wr_out = 1'h0;
      sfr_addr_out = ~a;
      sfr_wdata_out = ~d;
   endtask : wr
endmodule : tag_cpu_model

// ===== verification/tag_guard_chk.sv
module tag_guard_chk
   import tag_pkg::*;
#(
   parameter int MC_CLKS = TAG_MC_CLKS,
   parameter logic [7:0] WDOG_ADDR = TAG_WDOG_ADDR_DEF
)
(
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire logic [7:0] watchdog_control_out,
   input wire logic window_open_out,
   input wire logic wr_dropped_out
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int OMIN = 2 * MC_CLKS + 1;
   localparam int OMAX = 3 * MC_CLKS;
   // decoded write kinds
   wire wk = sfr_wr_in && sfr_addr_in == TAG_KEY_ADDR;
   wire kaa = wk && sfr_wdata_in == TAG_KEY_FIRST;
   wire k55 = wk && sfr_wdata_in == TAG_KEY_SECOND;
   wire pw = sfr_wr_in && sfr_addr_in == WDOG_ADDR;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   a_key_opens: assert property (kaa ##2 k55 |=> window_open_out) else $error("no open");
   a_open_cause: assert property ($rose(window_open_out) |-> $past(k55)) else $error("bad open");
   a_open_hold: assert property ($rose(window_open_out) |-> window_open_out [*8]) else $error("short");
   a_open_ends: assert property ($rose(window_open_out) |-> ##[OMIN:OMAX] !window_open_out) else $error("long");
   a_drop_pulse: assert property (pw && !window_open_out |=> wr_dropped_out) else $error("no drop");
   a_closed_keep: assert property (pw && !window_open_out |=> $stable(watchdog_control_out)) else $error("wr");
   a_open_write: assert property (pw && window_open_out |=> watchdog_control_out == $past(sfr_wdata_in))
      else $error("no wr");
   a_wdog_cause: assert property ($changed(watchdog_control_out) |-> $past(pw && window_open_out))
      else $error("stray");
endmodule : tag_guard_chk
bind tag_guard tag_guard_chk #(.MC_CLKS(MC_CLKS), .WDOG_ADDR(WDOG_ADDR)) i_chk (.mclk_in, .sys_rst_in,
   .sfr_wr_in, .sfr_addr_in, .sfr_wdata_in, .watchdog_control_out, .window_open_out, .wr_dropped_out);

// ===== verification/tag_guard_tb_top.sv
module tag_guard_tb_top
   import tag_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
   $display("unexpected %s exp %h got %h", n, e, s); end end
   logic mclk_in = 1'h0, sys_rst_in = 1'h1, wr, drop, wopen, ok;
   logic [7:0] addr, wdata, wdog, v;
   int err_total, samples_checked, exp_wdog, seed = 32'h35c9;
   // first key, second address, second key, idle gap, delay to protected write
   logic [7:0] tc [6][5] = '{'{8'hAA, 8'hC7, 8'h55, 8'h00, 8'h00}, '{8'hAA, 8'hC7, 8'h55, 8'h0C, 8'h00},
      '{8'hAA, 8'hC7, 8'h33, 8'h00, 8'h00}, '{8'hAA, 8'hC6, 8'h55, 8'h00, 8'h00},
      '{8'h5A, 8'hC7, 8'h55, 8'h00, 8'h00}, '{8'hAA, 8'hC7, 8'h55, 8'h00, 8'h0D}};
   tag_guard i_tag_guard (.mclk_in, .sys_rst_in, .sfr_wr_in(wr), .sfr_addr_in(addr), .sfr_wdata_in(wdata),
      .watchdog_control_out(wdog), .window_open_out(wopen), .wr_dropped_out(drop));
   tag_cpu_model i_tag_cpu_model (.mclk_in, .sfr_wr_out(wr), .sfr_addr_out(addr), .sfr_wdata_out(wdata));
   ////////////////////////////////////////
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // clock and watchdog
   initial forever #2 mclk_in = ~mclk_in;
   initial
   begin
      #20000 err_total++;
      test_done();
   end
   // key sequences, each followed by a protected write
   initial
   begin
      repeat (2) @(posedge mclk_in);
      #1 sys_rst_in = 1'h0;
      `CHK("window_open", 1'h0, wopen)
      for (int i = 0; i < 6; i++)
      begin
         i_tag_cpu_model.wr(TAG_KEY_ADDR, tc[i][0]);
         repeat (tc[i][3]) @(posedge mclk_in);
         i_tag_cpu_model.wr(tc[i][1], tc[i][2]);
         ok = tc[i][0] == TAG_KEY_FIRST && tc[i][1] == TAG_KEY_ADDR && tc[i][2] == TAG_KEY_SECOND
            && tc[i][3] < TAG_MC_CLKS;
         `CHK("window_open", ok, wopen)
         repeat (tc[i][4]) @(posedge mclk_in);
         v = 8'($random(seed));
         i_tag_cpu_model.wr(TAG_WDOG_ADDR_DEF, v);
         ok = ok && tc[i][4] < TAG_MC_CLKS;
         if (ok)
            exp_wdog = v;
         `CHK("watchdog_control", exp_wdog[7:0], wdog)
         `CHK("wr_dropped", !ok, drop)
         $display("test %0d done", i);
         repeat (16) @(posedge mclk_in);
      end
      test_done();
   end
endmodule : tag_guard_tb_top
